// [shared/bli_map.vh]
// Opcodes, flag positions and clock-state counts of the byte load executor.
`ifndef BLI_MAP_VH
`define BLI_MAP_VH
// ---------------------------------------------------------------
// Opcodes
// ---------------------------------------------------------------
`define BLI_OP_ST_PTR_IMM   8'h36
`define BLI_OP_LDA_GP1      8'h0A
`define BLI_OP_LDA_GP2      8'h1A
`define BLI_OP_LDA_DIR      8'h3A
`define BLI_OP_STA_GP1      8'h02
`define BLI_OP_STA_GP2      8'h12
`define BLI_OP_STA_DIR      8'h32
`define BLI_PFX_IDX1        8'hDD
`define BLI_PFX_IDX2        8'hFD
`define BLI_PFX_EXT         8'hED
`define BLI_OP_LDA_VEC      8'h57
`define BLI_OP_LDA_REF      8'h5F
`define BLI_OP_LDVEC_A      8'h47
`define BLI_OP_LDREF_A      8'h4F
// ---------------------------------------------------------------
// Flag bit positions
// ---------------------------------------------------------------
`define BLI_F_SIGN          7
`define BLI_F_ZERO          6
`define BLI_F_HALF          4
`define BLI_F_PV            2
`define BLI_F_SUB           1
`define BLI_F_CARRY         0
// ---------------------------------------------------------------
// Clock states per machine cycle kind
// ---------------------------------------------------------------
`define BLI_T_FETCH         3'h4
`define BLI_T_MEM           3'h3
`define BLI_T_CALC          3'h5
// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define BLI_RST_BYTE        8'h00
`define BLI_RST_WORD        16'h0000
`endif

// [src/bli_tstate_timer.v]
// Clock-state counter that marks the last state of each machine cycle.
`include "bli_map.vh"
module bli_tstate_timer (
  input  wire       sys_clk_i,
  input  wire       arst_n_i,
  input  wire       start_i,
  input  wire [2:0] len_i,
  output wire       last_o,
  output reg  [2:0] tstate_o
);
  reg [2:0] len_reg;

  // Counts clock states within the current machine cycle. The start pulse
  // stands in the first state, so the count resumes at state two.
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tstate_o <= 3'h0;
      len_reg  <= 3'h0;
    end else if (start_i) begin
      tstate_o <= 3'h2;
      len_reg  <= len_i;
    end else if (tstate_o != 3'h0 && tstate_o != len_reg) begin
      tstate_o <= tstate_o + 3'h1;
    end else begin
      tstate_o <= 3'h0;
    end
  end

  // The cycle ends in its final clock state.
  assign last_o = (tstate_o != 3'h0) && (tstate_o == len_reg);
endmodule // bli_tstate_timer

// [src/bli_addr_gen.v]
// Effective address adder for the displaced index forms.
`include "bli_map.vh"
module bli_addr_gen (
  input  wire [15:0] base_i,
  input  wire [7:0]  disp_i,
  output wire [15:0] addr_o
);
  // Displacement is sign extended; the sum wraps at 16 bits.
  assign addr_o = base_i + {{8{disp_i[7]}}, disp_i}; // see RULE15
endmodule // bli_addr_gen

// [src/bli_core.v]
// Execution unit for the 8-bit accumulator and immediate move instructions.
// Summary of operation
// RULE1: 36 stores immediate via pointer pair, 10 states.
// RULE2: First index store immediate, 19 states.
// RULE3: Second index store immediate, 19 states.
// RULE4: 0A loads accumulator via first pair.
// RULE5: Accumulator load via second pair, 7 states.
// RULE6: 3A loads accumulator from direct address.
// RULE7: Accumulator store via first pair, 7 states.
// RULE8: Accumulator store via second pair, 7 states.
// RULE9: Direct address accumulator store, 13 states.
// RULE10: Vector to accumulator sets flags, 9 states.
// RULE11: Refresh to accumulator sets flags, 9 states.
// RULE12: Interrupt during those loads clears parity.
// RULE13: Accumulator to vector, 9 states, no flags.
// RULE14: Accumulator to refresh, 9 states, no flags.
// RULE15: Displacement sign extended, address wraps.
// RULE16: Memory answers within each machine cycle.
`include "bli_map.vh"
module bli_core (
  input  wire        sys_clk_i,
  input  wire        arst_n_i,
  input  wire        start_i,
  input  wire [15:0] pc_i,
  input  wire [15:0] ptr_pair_i,
  input  wire [15:0] gen1_pair_i,
  input  wire [15:0] gen2_pair_i,
  input  wire [15:0] idx1_i,
  input  wire [15:0] idx2_i,
  input  wire [7:0]  acc_i,
  input  wire [7:0]  flags_i,
  input  wire [7:0]  vec_i,
  input  wire [7:0]  ref_i,
  input  wire        saved_irq_enable_latch_i,
  input  wire        irq_accept_i,
  input  wire [7:0]  mem_rdata_i,
  output reg  [15:0] mem_addr_o,
  output reg  [7:0]  mem_wdata_o,
  output wire        mem_rd_o,
  output wire        mem_wr_o,
  output reg  [15:0] pc_o,
  output reg  [7:0]  acc_o,
  output reg  [7:0]  flags_o,
  output reg  [7:0]  vec_o,
  output reg  [7:0]  ref_o,
  output reg         acc_we_o,
  output reg         flags_we_o,
  output reg         vec_we_o,
  output reg         ref_we_o,
  output wire        busy_o,
  output reg         done_o,
  output reg         illegal_o
);
  // ---------------------------------------------------------------
  // Machine cycle kinds, one-hot
  // ---------------------------------------------------------------
  localparam [7:0] S_IDLE  = 8'h01;
  localparam [7:0] S_FETCH = 8'h02;
  localparam [7:0] S_RDOPR = 8'h04;
  localparam [7:0] S_CALC  = 8'h08;
  localparam [7:0] S_MRD   = 8'h10;
  localparam [7:0] S_MWR   = 8'h20;
  localparam [7:0] S_XFER  = 8'h40;
  localparam [7:0] S_DONE  = 8'h80;

  reg [7:0]  state_reg;
  reg [7:0]  op_reg;
  reg [1:0]  pfx_reg;
  reg [1:0]  nopr_reg;
  reg [7:0]  lo_reg;
  reg [15:0] addr_reg;
  reg [7:0]  acc_reg;
  reg        irq_seen_reg;
  reg        go_reg;
  reg [2:0]  len_reg;
  wire       last;
  wire [2:0] tstate;
  wire [15:0] idx_sum;

  // ---------------------------------------------------------------
  // Sub-blocks
  // ---------------------------------------------------------------
  // Clock-state timer of the current machine cycle.
  bli_tstate_timer u_timer (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .start_i   (go_reg),
    .len_i     (len_reg),
    .last_o    (last),
    .tstate_o  (tstate)
  );

  // Index pointer plus displacement for the displaced stores.
  bli_addr_gen u_addr (
    .base_i (pfx_reg[1] ? idx2_i : idx1_i),
    .disp_i (lo_reg),
    .addr_o (idx_sum)
  );

  // The go pulse is high in the first clock state of every machine cycle, when
  // the timer still reads zero; the timer then counts on from state two, so a
  // machine cycle follows the one before it with no idle state between them.
  // Memory strobes are held through the whole read or write cycle.
  assign mem_rd_o = (tstate != 3'h0 || go_reg) &&
                    (state_reg == S_FETCH || state_reg == S_RDOPR || state_reg == S_CALC ||
                     state_reg == S_MRD || state_reg == S_XFER);
  assign mem_wr_o = (tstate != 3'h0 || go_reg) && (state_reg == S_MWR);
  assign busy_o   = (state_reg != S_IDLE);

  // Address presented on the bus for the active cycle.
  always @* begin
    if (state_reg == S_MRD || state_reg == S_MWR)
      mem_addr_o = addr_reg;
    else
      mem_addr_o = pc_o;
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Each machine-cycle arm waits for the last clock state of its cycle, then names
  // the next cycle kind and its length in clock states, or moves to S_DONE, or to S_IDLE on an unknown opcode.
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg    <= S_IDLE;
      op_reg       <= `BLI_RST_BYTE;
      pfx_reg      <= 2'h0;
      nopr_reg     <= 2'h0;
      lo_reg       <= `BLI_RST_BYTE;
      addr_reg     <= `BLI_RST_WORD;
      acc_reg      <= `BLI_RST_BYTE;
      irq_seen_reg <= 1'b0;
      go_reg       <= 1'b0;
      len_reg      <= 3'h0;
      pc_o         <= `BLI_RST_WORD;
      mem_wdata_o  <= `BLI_RST_BYTE;
      acc_o        <= `BLI_RST_BYTE;
      flags_o      <= `BLI_RST_BYTE;
      vec_o        <= `BLI_RST_BYTE;
      ref_o        <= `BLI_RST_BYTE;
      acc_we_o     <= 1'b0;
      flags_we_o   <= 1'b0;
      vec_we_o     <= 1'b0;
      ref_we_o     <= 1'b0;
      done_o       <= 1'b0;
      illegal_o    <= 1'b0;
    end else begin
      go_reg     <= 1'b0;
      acc_we_o   <= 1'b0;
      flags_we_o <= 1'b0;
      vec_we_o   <= 1'b0;
      ref_we_o   <= 1'b0;
      done_o     <= 1'b0;
      illegal_o  <= 1'b0;
      if (irq_accept_i && state_reg != S_IDLE)
        irq_seen_reg <= 1'b1; // see RULE12
      case (state_reg)
        // A start request is taken only here, so one given while busy is ignored.
        S_IDLE: begin
          if (start_i) begin
            pc_o         <= pc_i;
            pfx_reg      <= 2'h0;
            acc_reg      <= acc_i;
            irq_seen_reg <= irq_accept_i;
            state_reg    <= S_FETCH;
            go_reg       <= 1'b1;
            len_reg      <= `BLI_T_FETCH;
          end
        end
        S_FETCH: begin
          if (last) begin
            pc_o <= pc_o + 16'h0001;
            go_reg <= 1'b1;
            if (pfx_reg == 2'h0 && (mem_rdata_i == `BLI_PFX_IDX1 ||
                mem_rdata_i == `BLI_PFX_IDX2 || mem_rdata_i == `BLI_PFX_EXT)) begin
              // A prefix costs its own 4-state fetch before the opcode.
              pfx_reg <= (mem_rdata_i == `BLI_PFX_IDX1) ? 2'h1 :
                         (mem_rdata_i == `BLI_PFX_IDX2) ? 2'h2 : 2'h3;
              len_reg <= `BLI_T_FETCH;
              if (mem_rdata_i == `BLI_PFX_EXT) begin
                // The opcode after this prefix is read in one 5-state cycle.
                len_reg   <= `BLI_T_CALC;
                state_reg <= S_XFER; // see RULE10, RULE13
              end
            end else begin
              op_reg <= mem_rdata_i;
              len_reg <= `BLI_T_MEM;
              state_reg <= S_RDOPR;
              if ((pfx_reg == 2'h1 || pfx_reg == 2'h2) &&
                  mem_rdata_i == `BLI_OP_ST_PTR_IMM) begin
                nopr_reg <= 2'h2; // see RULE2, RULE3
              end else if (pfx_reg == 2'h0 && mem_rdata_i == `BLI_OP_ST_PTR_IMM) begin
                nopr_reg <= 2'h1; // see RULE1
              end else if (pfx_reg == 2'h0 && (mem_rdata_i == `BLI_OP_LDA_DIR ||
                           mem_rdata_i == `BLI_OP_STA_DIR)) begin
                nopr_reg <= 2'h2; // see RULE6, RULE9
              end else if (pfx_reg == 2'h0 && (mem_rdata_i == `BLI_OP_LDA_GP1 ||
                           mem_rdata_i == `BLI_OP_LDA_GP2)) begin
                addr_reg  <= (mem_rdata_i == `BLI_OP_LDA_GP1) ? gen1_pair_i : gen2_pair_i;
                state_reg <= S_MRD; // see RULE4, RULE5
              end else if (pfx_reg == 2'h0 && (mem_rdata_i == `BLI_OP_STA_GP1 ||
                           mem_rdata_i == `BLI_OP_STA_GP2)) begin
                addr_reg    <= (mem_rdata_i == `BLI_OP_STA_GP1) ? gen1_pair_i : gen2_pair_i;
                mem_wdata_o <= acc_reg;
                state_reg   <= S_MWR; // see RULE7, RULE8
              end else begin
                go_reg    <= 1'b0;
                illegal_o <= 1'b1;
                state_reg <= S_IDLE;
              end
            end
          end
        end
        S_RDOPR: begin
          if (last) begin
            pc_o     <= pc_o + 16'h0001;
            nopr_reg <= nopr_reg - 2'h1;
            go_reg   <= 1'b1;
            len_reg  <= `BLI_T_MEM;
            if (nopr_reg == 2'h2) begin
              lo_reg <= mem_rdata_i; // Low address byte or displacement first.
              if (pfx_reg != 2'h0) begin
                // The data byte read and the index sum share one 5-state cycle.
                len_reg   <= `BLI_T_CALC;
                state_reg <= S_CALC; // see RULE2, RULE3
              end
            end else if (op_reg == `BLI_OP_ST_PTR_IMM) begin
              addr_reg    <= ptr_pair_i;
              mem_wdata_o <= mem_rdata_i;
              state_reg   <= S_MWR; // see RULE1
            end else begin
              addr_reg <= {mem_rdata_i, lo_reg};
              if (op_reg == `BLI_OP_LDA_DIR) begin
                state_reg <= S_MRD; // see RULE6
              end else begin
                mem_wdata_o <= acc_reg;
                state_reg   <= S_MWR; // see RULE9
              end
            end
          end
        end
        S_CALC: begin
          // Five-state read of the data byte while the index sum settles.
          if (last) begin
            pc_o        <= pc_o + 16'h0001;
            mem_wdata_o <= mem_rdata_i;
            addr_reg    <= idx_sum; // see RULE15
            go_reg      <= 1'b1;
            len_reg     <= `BLI_T_MEM;
            state_reg   <= S_MWR; // see RULE2, RULE3
          end
        end
        S_MRD: begin
          if (last) begin
            acc_o     <= mem_rdata_i; // see RULE16
            acc_we_o  <= 1'b1;
            state_reg <= S_DONE;
          end
        end
        S_MWR: begin
          if (last)
            state_reg <= S_DONE;
        end
        S_XFER: begin
          // Opcode read after the transfer prefix; the move lands at its end.
          if (last) begin
            pc_o      <= pc_o + 16'h0001;
            state_reg <= S_DONE;
            if (mem_rdata_i == `BLI_OP_LDA_VEC || mem_rdata_i == `BLI_OP_LDA_REF) begin
              acc_o      <= (mem_rdata_i == `BLI_OP_LDA_VEC) ? vec_i : ref_i;
              acc_we_o   <= 1'b1;
              flags_we_o <= 1'b1;
              flags_o    <= flags_i;
              flags_o[`BLI_F_SIGN] <= (mem_rdata_i == `BLI_OP_LDA_VEC) ? vec_i[7] : ref_i[7];
              flags_o[`BLI_F_ZERO] <= (mem_rdata_i == `BLI_OP_LDA_VEC) ?
                                      (vec_i == 8'h00) : (ref_i == 8'h00); // see RULE10, RULE11
              flags_o[`BLI_F_HALF] <= 1'b0;
              flags_o[`BLI_F_SUB]  <= 1'b0;
              flags_o[`BLI_F_PV]   <= saved_irq_enable_latch_i &
                                      ~(irq_seen_reg | irq_accept_i); // see RULE12
            end else if (mem_rdata_i == `BLI_OP_LDVEC_A) begin
              vec_o    <= acc_reg;
              vec_we_o <= 1'b1; // see RULE13
            end else if (mem_rdata_i == `BLI_OP_LDREF_A) begin
              ref_o    <= acc_reg;
              ref_we_o <= 1'b1; // see RULE14
            end else begin
              // Unknown second bytes are refused like unknown opcodes, with no done.
              illegal_o <= 1'b1;
              state_reg <= S_IDLE;
            end
          end
        end
        S_DONE: begin
          done_o    <= 1'b1;
          state_reg <= S_IDLE;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end
endmodule // bli_core

// [test/bli_mem_model.sv]
// Behavioural external memory on the processor bus of the byte load executor.
module bli_mem_model (
  input  wire        sys_clk_i,
  input  wire [15:0] mem_addr_i,
  input  wire [7:0]  mem_wdata_i,
  input  wire        mem_rd_i,
  input  wire        mem_wr_i,
  output logic [7:0] mem_rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];
  logic [7:0] last_reg = 8'h5A;
  // Reads answer within the state; a released bus shows the inverse of the last byte.
  always @* begin
    if (mem_rd_i) mem_rdata_o = mem[mem_addr_i];
    else mem_rdata_o = ~last_reg;
  end
  // Writes are taken at every write state, so the final state's byte stands.
  always @(posedge sys_clk_i) begin
    if (mem_wr_i) mem[mem_addr_i] <= mem_wdata_i;
    if (mem_rd_i) last_reg <= mem[mem_addr_i];
  end
endmodule // bli_mem_model

// [test/bli_monitor.sv]
// Concurrent checks on the ports of the byte load executor.
module bli_monitor (
  input wire        sys_clk_i,
  input wire        arst_n_i,
  input wire        start_i,
  input wire        busy_o,
  input wire        done_o,
  input wire [15:0] pc_i,
  input wire [7:0]  acc_i,
  input wire [7:0]  flags_i,
  input wire        saved_irq_enable_latch_i,
  input wire [15:0] mem_addr_o,
  input wire        mem_rd_o,
  input wire        mem_wr_o,
  input wire [7:0]  acc_o,
  input wire [7:0]  flags_o,
  input wire [7:0]  vec_o,
  input wire [7:0]  ref_o,
  input wire        acc_we_o,
  input wire        flags_we_o,
  input wire        vec_we_o,
  input wire        ref_we_o
);
  // ---------------------------------------------------------------
  // Port properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  // An opcode fetch reads four states; a memory write stands three states.
  sequence s_fetch4;
    (mem_rd_o && busy_o && mem_addr_o == pc_i) [*4];
  endsequence
  sequence s_wr3;
    mem_wr_o [*3] ##1 !mem_wr_o;
  endsequence
  property p_fetch;
    start_i && !busy_o |=> s_fetch4;
  endproperty
  property p_wr_len;
    $rose(mem_wr_o) |-> s_wr3;
  endproperty
  property p_idle;
    !busy_o |-> !mem_rd_o && !mem_wr_o;
  endproperty
  property p_done;
    acc_we_o || flags_we_o || vec_we_o || ref_we_o |=> done_o ##1 !done_o;
  endproperty
  property p_sz;
    flags_we_o |-> flags_o[7] == acc_o[7] && flags_o[6] == (acc_o == 8'h00)
      && !flags_o[4] && !flags_o[1];
  endproperty
  property p_carry;
    flags_we_o |-> flags_o[0] == flags_i[0];
  endproperty
  property p_pv;
    flags_we_o && !saved_irq_enable_latch_i |-> !flags_o[2];
  endproperty
  property p_copy;
    (vec_we_o |-> vec_o == acc_i) and (ref_we_o |-> ref_o == acc_i);
  endproperty
  a_fetch: assert property (p_fetch) else $error("opcode fetch wrong");
  a_wr_len: assert property (p_wr_len) else $error("write length wrong");
  a_idle: assert property (p_idle) else $error("strobe while idle");
  a_done: assert property (p_done) else $error("done pulse wrong");
  a_sz: assert property (p_sz) else $error("flag result wrong");
  a_carry: assert property (p_carry) else $error("carry changed");
  a_pv: assert property (p_pv) else $error("parity flag wrong");
  a_copy: assert property (p_copy) else $error("copy wrong");
endmodule // bli_monitor

bind bli_core bli_monitor chk (
  .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .start_i(start_i), .busy_o(busy_o),
  .done_o(done_o), .pc_i(pc_i), .acc_i(acc_i), .flags_i(flags_i),
  .saved_irq_enable_latch_i(saved_irq_enable_latch_i), .mem_addr_o(mem_addr_o),
  .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .acc_o(acc_o), .flags_o(flags_o),
  .vec_o(vec_o), .ref_o(ref_o), .acc_we_o(acc_we_o), .flags_we_o(flags_we_o),
  .vec_we_o(vec_we_o), .ref_we_o(ref_we_o)
);

// [test/test_byte_load_instruction_group.sv]
// Self-checking bench of the byte load executor with an external memory.
module test_byte_load_instruction_group;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] PC = 16'h1000;
  logic        clk = 1'b0, rst_n = 1'b0, start = 1'b0, latch = 1'b0, irq = 1'b0;
  logic [7:0]  acc = 8'h00, flg = 8'h00, vec = 8'h00, rf = 8'h00;
  logic [15:0] ptr = 16'h0000, g1 = 16'h0000, g2 = 16'h0000, x1 = 16'h0000, x2 = 16'h0000;
  wire  [15:0] addr, pc_q;
  wire  [7:0]  wdata, rdata, acc_q, flg_q, vec_q, ref_q;
  wire         rd, wr, awe, fwe, vwe, rwe, busy, done, ill;
  logic [7:0]  r_acc, r_flg, r_vec, r_ref;
  int          n_cyc, n_fwe, n_mismatch = 0, cmp_count = 0;
  // ---------------------------------------------------------------
  // Design and memory
  // ---------------------------------------------------------------
  bli_core uut (
    .sys_clk_i(clk), .arst_n_i(rst_n), .start_i(start), .pc_i(PC), .ptr_pair_i(ptr),
    .gen1_pair_i(g1), .gen2_pair_i(g2), .idx1_i(x1), .idx2_i(x2), .acc_i(acc),
    .flags_i(flg), .vec_i(vec), .ref_i(rf), .saved_irq_enable_latch_i(latch),
    .irq_accept_i(irq), .mem_rdata_i(rdata), .mem_addr_o(addr), .mem_wdata_o(wdata),
    .mem_rd_o(rd), .mem_wr_o(wr), .pc_o(pc_q), .acc_o(acc_q), .flags_o(flg_q), .vec_o(vec_q),
    .ref_o(ref_q), .acc_we_o(awe), .flags_we_o(fwe), .vec_we_o(vwe), .ref_we_o(rwe),
    .busy_o(busy), .done_o(done), .illegal_o(ill)
  );
  bli_mem_model ext_mem (
    .sys_clk_i(clk), .mem_addr_i(addr), .mem_wdata_i(wdata), .mem_rd_i(rd),
    .mem_wr_i(wr), .mem_rdata_o(rdata)
  );
  // Compares one result and counts it.
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Checks the cycle count from start to done, two more than the states.
  task automatic chk_t(input logic [7:0] states);
    chk("cycles", {8'h00, states} + 16'h0002, n_cyc[15:0]);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("compared %0d mismatched %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Places code at the start address, runs one instruction and gathers results.
  task automatic run(input logic [31:0] code, input int nb);
    for (int i = 0; i < nb; i++) ext_mem.mem[PC + i] = code[31 - 8 * i -: 8];
    {r_acc, r_flg, r_vec, r_ref} = 32'hXXXXXXXX;
    // The cycle after the start edge counts as the first.
    n_cyc = 1;
    n_fwe = 0;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    while (done !== 1'b1 && n_cyc < 60) begin
      @(negedge clk);
      n_cyc++;
      if (awe === 1'b1) r_acc = acc_q;
      if (fwe === 1'b1) begin
        r_flg = flg_q;
        n_fwe++;
      end
      if (vwe === 1'b1) r_vec = vec_q;
      if (rwe === 1'b1) r_ref = ref_q;
    end
    if (done !== 1'b1) begin
      chk("done", 16'h0001, {15'h0000, done});
      finish_test();
    end
    @(negedge clk);
  endtask
  // Immediate store through the pointer pair.
  task automatic t_ptr_imm();
    ptr = 16'h4444;
    run({8'h36, 8'h28, 16'h0000}, 2);
    chk_t(8'h0A);
    chk("mem", 16'h0028, {8'h00, ext_mem.mem[16'h4444]});
    $display("test ptr_imm done");
  endtask
  // Displaced immediate stores, a negative offset and a wrap past the top.
  task automatic t_idx();
    x1 = 16'h0010;
    x2 = 16'hFFF0;
    run({8'hDD, 8'h36, 8'hF0, 8'h5A}, 4);
    chk_t(8'h13);
    chk("mem", 16'h005A, {8'h00, ext_mem.mem[16'h0000]});
    run({8'hFD, 8'h36, 8'h20, 8'hA5}, 4);
    chk_t(8'h13);
    chk("mem", 16'h00A5, {8'h00, ext_mem.mem[16'h0010]});
    chk("pc", 16'h1004, pc_q);
    $display("test idx done");
  endtask
  // Accumulator loads via both pairs and a direct address with a swapped decoy.
  task automatic t_ld_acc();
    g1 = 16'h4747;
    g2 = 16'h30A2;
    ext_mem.mem[16'h4747] = 8'h12;
    ext_mem.mem[16'h30A2] = 8'h22;
    ext_mem.mem[16'h8832] = 8'h04;
    ext_mem.mem[16'h3288] = 8'hEE;
    run({8'h0A, 24'h000000}, 1);
    chk_t(8'h07);
    chk("acc", 16'h0012, {8'h00, r_acc});
    run({8'h1A, 24'h000000}, 1);
    chk_t(8'h07);
    chk("acc", 16'h0022, {8'h00, r_acc});
    run({8'h3A, 8'h32, 8'h88, 8'h00}, 3);
    chk_t(8'h0D);
    chk("acc", 16'h0004, {8'h00, r_acc});
    chk("pc", 16'h1003, pc_q);
    chk("flag writes", 16'h0000, n_fwe[15:0]);
    $display("test ld_acc done");
  endtask
  // Accumulator stores via both pairs and a direct address.
  task automatic t_st_acc();
    acc = 8'h7A;
    g1 = 16'h1212;
    run({8'h02, 24'h000000}, 1);
    chk_t(8'h07);
    chk("mem", 16'h007A, {8'h00, ext_mem.mem[16'h1212]});
    acc = 8'hA0;
    g2 = 16'h1128;
    run({8'h12, 24'h000000}, 1);
    chk_t(8'h07);
    chk("mem", 16'h00A0, {8'h00, ext_mem.mem[16'h1128]});
    acc = 8'hD7;
    run({8'h32, 8'h41, 8'h31, 8'h00}, 3);
    chk_t(8'h0D);
    chk("mem", 16'h00D7, {8'h00, ext_mem.mem[16'h3141]});
    chk("flag writes", 16'h0000, n_fwe[15:0]);
    $display("test st_acc done");
  endtask
  // Vector and refresh reads with flags, once with an interrupt accepted.
  task automatic t_ld_ai();
    flg = 8'h13;
    vec = 8'h80;
    latch = 1'b1;
    run({8'hED, 8'h57, 16'h0000}, 2);
    chk_t(8'h09);
    chk("flags", 16'h0085, {8'h00, r_flg & 8'hD7});
    chk("pc", 16'h1002, pc_q);
    rf = 8'h00;
    latch = 1'b0;
    run({8'hED, 8'h5F, 16'h0000}, 2);
    chk_t(8'h09);
    chk("acc", 16'h0000, {8'h00, r_acc});
    chk("flags", 16'h0041, {8'h00, r_flg & 8'hD7});
    latch = 1'b1;
    irq = 1'b1;
    vec = 8'h3C;
    run({8'hED, 8'h57, 16'h0000}, 2);
    irq = 1'b0;
    chk("flags", 16'h0001, {8'h00, r_flg & 8'hD7});
    $display("test ld_ai done");
  endtask
  // Accumulator copied into the vector and refresh registers.
  task automatic t_ld_ia();
    acc = 8'h66;
    run({8'hED, 8'h47, 16'h0000}, 2);
    chk_t(8'h09);
    chk("vec", 16'h0066, {8'h00, r_vec});
    acc = 8'h99;
    run({8'hED, 8'h4F, 16'h0000}, 2);
    chk_t(8'h09);
    chk("ref", 16'h0099, {8'h00, r_ref});
    chk("flag writes", 16'h0000, n_fwe[15:0]);
    $display("test ld_ia done");
  endtask
  // An unsupported opcode pulses the illegal flag once and returns to idle with no done.
  task automatic t_bad();
    int n_ill;
    ext_mem.mem[PC] = 8'h00;
    n_ill = 0;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (8) begin
      @(negedge clk);
      if (ill === 1'b1) n_ill++;
      if (done === 1'b1) n_ill = n_ill + 16;
    end
    chk("illegal pulses", 16'h0001, n_ill[15:0]);
    chk("busy", 16'h0000, {15'h0000, busy});
    $display("test bad done");
  endtask
  // Makes the 40 ns clock.
  initial begin
    forever #20 clk = ~clk;
  end
  // Holds reset for 20 cycles, then runs every scenario.
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t_ptr_imm();
    t_idx();
    t_ld_acc();
    t_st_acc();
    t_ld_ai();
    t_ld_ia();
    t_bad();
    finish_test();
  end
endmodule // test_byte_load_instruction_group
